// *** lvd_pkg.sv ***
// Package of constants for the low-voltage detector control block
package lvd_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [15:0] LVD_ADDR_CTRL    = 16'hff50;
    localparam logic [15:0] LVD_ADDR_LEVEL   = 16'hff51;
    localparam logic [15:0] LVD_ADDR_CAUSE   = 16'hff52;
    localparam logic [15:0] LVD_ADDR_IRQ_ST  = 16'hff53;
    localparam logic [15:0] LVD_ADDR_IRQ_EN  = 16'hff54;
    localparam logic [15:0] LVD_ADDR_IRQ_CLR = 16'hff55;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int LVD_CTRL_EN_BIT     = 7;
    localparam int LVD_CTRL_MODE_BIT   = 1;
    localparam int LVD_CTRL_FLAG_BIT   = 0;
    localparam int LVD_CAUSE_LVD_BIT   = 0;
    localparam int LVD_IRQ_REQ_BIT     = 0;
    localparam logic [7:0] LVD_CTRL_RST  = 8'h00;
    localparam logic [3:0] LVD_LEVEL_RST = 4'h0;
    localparam logic [3:0] LVD_LEVEL_MAX = 4'h9;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int LVD_CLK_MHZ       = 100;
    localparam int LVD_SETTLE_US     = 200;
    localparam int LVD_SETTLE_CYCLES = LVD_SETTLE_US * LVD_CLK_MHZ;

endpackage : lvd_pkg

// *** lvd_ctrl.sv ***
// Control logic of the supply low-voltage detector
`timescale 1ns/1ns
// Contract
// - Level register takes whole-byte writes only
// - Level cleared by reset except self reset
// - Codes 0-9 select ten thresholds, others prohibited
// - Disable before changing level code
// - Reset mode holds reset while below threshold
// - Interrupt mode raises request when below
// - Entering reset mode alone causes no reset
// - Flag drives request only enabled, interrupt mode
// - Self reset sets cause bit, keeps control
// - Control: enable b7, mode b1, flag b0
module lvd_ctrl
    import lvd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        lvd_rst_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        cmp_below_i,
    output logic      [3:0]  level_sel_o,
    output logic             level_valid_o,
    output logic             cmp_enable_o,
    output logic             lvd_reset_req_o,
    output logic             undervoltage_irq_o,
    output logic             irq_o
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic       detector_enable_bit_r;
    logic       response_mode_select_r;
    logic [3:0] detect_level_select_r;
    logic       cmp_meta_r;
    logic       cmp_sync_r;
    logic       below_level_flag;
    logic       reset_cause_undervoltage_r;
    logic       irq_status_r;
    logic       irq_enable_r;
    logic       irq_line_q_r;
    logic       irq_edge;
    logic [7:0] rdata_nxt;
    logic       is_rst_r;

    function automatic logic hit(input logic [15:0] a);
        hit = (addr_i == a);
    endfunction : hit

    // Codes above 9 have no threshold behind them
    function automatic logic level_legal(input logic [3:0] code);
        level_legal = (code <= LVD_LEVEL_MAX);
    endfunction : level_legal

    // ---------------------------------------------------------------
    // Comparator synchroniser
    // ---------------------------------------------------------------
    // Analog comparator output is asynchronous to clk_i
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end
        else
        begin
            cmp_meta_r <= cmp_below_i;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // Flag reads zero while the detector is off
    assign below_level_flag = detector_enable_bit_r & cmp_sync_r;

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    // The detector's own reset keeps settings, so only rst_i clears
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            detector_enable_bit_r  <= LVD_CTRL_RST[LVD_CTRL_EN_BIT];
            response_mode_select_r <= LVD_CTRL_RST[LVD_CTRL_MODE_BIT];
        end
        else if (wr_i && hit(LVD_ADDR_CTRL))
        begin
            // Bits 2-6 and the read-only flag are dropped
            detector_enable_bit_r  <= wdata_i[LVD_CTRL_EN_BIT];
            response_mode_select_r <= wdata_i[LVD_CTRL_MODE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Level select register
    // ---------------------------------------------------------------
    // Port is byte wide only, so every write replaces the whole code
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            detect_level_select_r <= LVD_LEVEL_RST;
        end
        else if (wr_i && hit(LVD_ADDR_LEVEL))
        begin
            detect_level_select_r <= wdata_i[3:0];
        end
    end

    // Code is passed to the selector unchanged; validity shown apart
    assign level_sel_o   = detect_level_select_r;
    // A rewrite while enabled leaves the threshold undefined for a cycle
    assign level_valid_o = level_legal(detect_level_select_r)
                         & ~(wr_i && hit(LVD_ADDR_LEVEL)
                             && detector_enable_bit_r);
    assign cmp_enable_o  = detector_enable_bit_r;

    // ---------------------------------------------------------------
    // Responses
    // ---------------------------------------------------------------
    // Reset only while below with mode set; entering the mode is silent
    assign lvd_reset_req_o = below_level_flag
                           & response_mode_select_r;
    assign undervoltage_irq_o = below_level_flag
                              & ~response_mode_select_r;

    // ---------------------------------------------------------------
    // Reset cause
    // ---------------------------------------------------------------
    // Set by lvd_rst_i; cleared when the caller reads it or by rst_i
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reset_cause_undervoltage_r <= 1'b0;
        end
        else if (lvd_rst_i)
        begin
            reset_cause_undervoltage_r <= 1'b1;
        end
        else if (rd_i && hit(LVD_ADDR_CAUSE))
        begin
            reset_cause_undervoltage_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status, enable and clear
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_line_q_r <= 1'b0;
            is_rst_r     <= 1'b0;
        end
        else
        begin
            irq_line_q_r <= undervoltage_irq_o;
            is_rst_r     <= 1'b1;
        end
    end

    assign irq_edge = undervoltage_irq_o & ~irq_line_q_r & is_rst_r;

    // A new edge in the clear cycle wins over the clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_status_r <= 1'b0;
        end
        else if (irq_edge)
        begin
            irq_status_r <= 1'b1;
        end
        else if (wr_i && hit(LVD_ADDR_IRQ_CLR) && wdata_i[LVD_IRQ_REQ_BIT])
        begin
            irq_status_r <= 1'b0;
        end
    end

    // Enable resets to masked, so enabling the detector raises nothing
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_enable_r <= 1'b0;
        end
        else if (wr_i && hit(LVD_ADDR_IRQ_EN))
        begin
            irq_enable_r <= wdata_i[LVD_IRQ_REQ_BIT];
        end
    end

    assign irq_o = irq_status_r & irq_enable_r;

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (hit(LVD_ADDR_CTRL))
        begin
            rdata_nxt[LVD_CTRL_EN_BIT]   = detector_enable_bit_r;
            rdata_nxt[LVD_CTRL_MODE_BIT] = response_mode_select_r;
            rdata_nxt[LVD_CTRL_FLAG_BIT] = below_level_flag;
        end
        else if (hit(LVD_ADDR_LEVEL))
        begin
            rdata_nxt[3:0] = detect_level_select_r;
        end
        else if (hit(LVD_ADDR_CAUSE))
        begin
            rdata_nxt[LVD_CAUSE_LVD_BIT] = reset_cause_undervoltage_r;
        end
        else if (hit(LVD_ADDR_IRQ_ST))
        begin
            rdata_nxt[LVD_IRQ_REQ_BIT] = irq_status_r;
        end
        else if (hit(LVD_ADDR_IRQ_EN))
        begin
            rdata_nxt[LVD_IRQ_REQ_BIT] = irq_enable_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            rdata_o <= rdata_nxt;
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

endmodule : lvd_ctrl

// *** lvd_cmp_model.sv ***
// Behavioural supply comparator with ten selectable thresholds
`timescale 1ns/1ns
module lvd_cmp_model
(
    input  wire logic        en_i,
    input  wire logic [3:0]  level_i,
    input  wire logic [12:0] supply_mv_i,
    output logic             below_o
);
    // Thresholds in millivolts, 4300 down to 2350
    localparam logic [12:0] THR [10] = '{13'h10cc, 13'h1004, 13'h0f3c,
        13'h0e74, 13'h0dac, 13'h0ce4, 13'h0c1c, 13'h0b22, 13'h0a28,
        13'h092e};
    // A prohibited code has no defined level, so report the worst case
    always_comb
        if (!en_i)
            below_o = 1'b0;
        else if (level_i > 4'h9)
            below_o = 1'b1;
        else
            below_o = supply_mv_i < THR[level_i];
endmodule : lvd_cmp_model

// *** lvd_ctrl_monitor.sv ***
// Port checker of the low-voltage detector control block
`timescale 1ns/1ns
module lvd_ctrl_monitor
    import lvd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        lvd_rst_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [3:0]  level_sel_o,
    input wire logic        cmp_below_i,
    input wire logic        level_valid_o,
    input wire logic        cmp_enable_o,
    input wire logic        lvd_reset_req_o,
    input wire logic        undervoltage_irq_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sync_low_a: assert property (!cmp_below_i [*3] |->
        !undervoltage_irq_o && !lvd_reset_req_o) else $error("late low");
    sync_high_a: assert property (cmp_below_i [*3] ##0
        cmp_enable_o [*3] |-> undervoltage_irq_o || lvd_reset_req_o)
        else $error("missed undervoltage");
    one_mode_a: assert property (!(undervoltage_irq_o
        && lvd_reset_req_o)) else $error("both responses active");
    off_quiet_a: assert property (!cmp_enable_o |->
        !undervoltage_irq_o && !lvd_reset_req_o) else $error("idle output");
    level_valid_a: assert property (level_sel_o > LVD_LEVEL_MAX |->
        !level_valid_o) else $error("prohibited code valid");
    self_reset_a: assert property (lvd_rst_i |=>
        $stable(level_sel_o) && $stable(cmp_enable_o))
        else $error("settings lost on self reset");
    ctrl_read_a: assert property (
        rd_i && addr_i == LVD_ADDR_CTRL |=>
        rdata_o[6:2] == 5'h00 && rdata_o[7] == $past(cmp_enable_o)
        && (!$past(lvd_reset_req_o) || rdata_o[1])
        && rdata_o[0] == $past(undervoltage_irq_o || lvd_reset_req_o))
        else $error("control read wrong");
    level_read_a: assert property (
        rd_i && addr_i == LVD_ADDR_LEVEL |=>
        rdata_o == {4'h0, $past(level_sel_o)}) else $error("level read wrong");
endmodule : lvd_ctrl_monitor

// *** lvd_ctrl_tb_top.sv ***
// Self-checking bench of the low-voltage detector control block
`timescale 1ns/1ns
module lvd_ctrl_tb_top
    import lvd_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, lvd_rst_i = 0, wr_i = 0, rd_i = 0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00, rdata_o;
    logic [3:0]  level_sel_o;
    logic        level_valid_o, cmp_enable_o, lvd_reset_req_o, cmp_below_i;
    logic        undervoltage_irq_o, irq_o;
    logic [12:0] supply_mv = 13'h1388;
    int          n_fail = 0, checked = 0;
    always #5 clk_i = ~clk_i;
    lvd_ctrl lvd_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .lvd_rst_i(lvd_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .cmp_below_i(cmp_below_i),
        .level_sel_o(level_sel_o), .level_valid_o(level_valid_o),
        .cmp_enable_o(cmp_enable_o), .lvd_reset_req_o(lvd_reset_req_o),
        .undervoltage_irq_o(undervoltage_irq_o), .irq_o(irq_o));
    lvd_cmp_model lvd_cmp_model_i (.en_i(cmp_enable_o), .level_i(level_sel_o),
        .supply_mv_i(supply_mv), .below_o(cmp_below_i));
    task chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task rd(string what, logic [15:0] a, logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(what, exp, rdata_o);
    endtask : rd
    // Comparator settles instantly in the model, so a few cycles suffice
    task wt(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wt
    task end_sim;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    initial
    begin
        // One settling wait plus under a hundred bus cycles, with margin
        repeat (LVD_SETTLE_CYCLES + 5000) @(posedge clk_i);
        n_fail++;
        end_sim();
    end
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", LVD_ADDR_CTRL, 8'h00);
        rd("level", LVD_ADDR_LEVEL, 8'h00);
        rd("unmapped", 16'hff60, 8'h00);
        wr(LVD_ADDR_LEVEL, 8'h0c);
        rd("level", LVD_ADDR_LEVEL, 8'h0c);
        chk("valid", 8'h00, {7'h00, level_valid_o});
        wr(LVD_ADDR_LEVEL, 8'h03);
        chk("valid", 8'h01, {7'h00, level_valid_o});
        rd("irq en", LVD_ADDR_IRQ_EN, 8'h00);
        wr(LVD_ADDR_CTRL, 8'h80);
        wt(LVD_SETTLE_CYCLES);
        rd("ctrl", LVD_ADDR_CTRL, 8'h80);
        wr(LVD_ADDR_IRQ_CLR, 8'h01);
        supply_mv = 13'h0e42; // 3650 mV, under the 3700 mV level
        wt(4);
        chk("uv irq", 8'h01, {7'h00, undervoltage_irq_o});
        chk("masked irq", 8'h00, {7'h00, irq_o});
        rd("ctrl", LVD_ADDR_CTRL, 8'h81);
        wr(LVD_ADDR_IRQ_EN, 8'h01);
        chk("irq", 8'h01, {7'h00, irq_o});
        supply_mv = 13'h0e74; // exactly at the level counts as good
        wt(4);
        rd("ctrl", LVD_ADDR_CTRL, 8'h80);
        wr(LVD_ADDR_IRQ_CLR, 8'h01);
        chk("irq cleared", 8'h00, {7'h00, irq_o});
        rd("status", LVD_ADDR_IRQ_ST, 8'h00);
        wr(LVD_ADDR_IRQ_EN, 8'h00);
        rd("ctrl", LVD_ADDR_CTRL, 8'h80);
        wr(LVD_ADDR_CTRL, 8'h82);
        wt(4);
        chk("no reset", 8'h00, {7'h00, lvd_reset_req_o});
        supply_mv = 13'h0bb8;
        wt(4);
        chk("reset req", 8'h01, {7'h00, lvd_reset_req_o});
        chk("uv off", 8'h00, {7'h00, undervoltage_irq_o});
        @(posedge clk_i);
        lvd_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        lvd_rst_i <= 1'b0;
        rd("cause", LVD_ADDR_CAUSE, 8'h01);
        rd("cause", LVD_ADDR_CAUSE, 8'h00);
        rd("ctrl", LVD_ADDR_CTRL, 8'h83);
        rd("level", LVD_ADDR_LEVEL, 8'h03);
        supply_mv = 13'h0e74;
        wt(4);
        chk("reset gone", 8'h00, {7'h00, lvd_reset_req_o});
        wr(LVD_ADDR_CTRL, 8'h80);
        wr(LVD_ADDR_CTRL, 8'h00);
        rd("ctrl", LVD_ADDR_CTRL, 8'h00);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd("level", LVD_ADDR_LEVEL, 8'h00);
        end_sim();
    end
endmodule : lvd_ctrl_tb_top
bind lvd_ctrl lvd_ctrl_monitor lvd_ctrl_monitor_i (.clk_i(clk_i),
    .rst_i(rst_i), .lvd_rst_i(lvd_rst_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .level_sel_o(level_sel_o), .cmp_below_i(cmp_below_i),
    .level_valid_o(level_valid_o), .cmp_enable_o(cmp_enable_o),
    .lvd_reset_req_o(lvd_reset_req_o),
    .undervoltage_irq_o(undervoltage_irq_o), .irq_o(irq_o));
